// ==== rtl/bit_sync.sv ====
module bit_sync (
  input  wire logic                                   mclk,
  input  wire logic                                   reset,
  input  wire logic [comparator_ctrl_pkg::SYNC_WIDTH-1:0] asyncIn,
  output logic      [comparator_ctrl_pkg::SYNC_WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [comparator_ctrl_pkg::SYNC_WIDTH-1:0] stage1;
    logic [comparator_ctrl_pkg::SYNC_WIDTH-1:0] stage2;
  } sync_type;

  sync_type s;
  sync_type next_s;

  // The first stage feeds only the second stage.
  always_comb begin
    next_s.stage1 = asyncIn;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign syncOut = s.stage2;

endmodule

// ==== rtl/comparator_ctrl_irq.sv ====
// Overview of operation
// R1 - Result bit high when positive exceeds negative.
// R2 - Raw comparator output synchronised, one-two cycles.
// R3 - Mux on, converter off: channel picks pin.
// R4 - Otherwise dedicated negative pin is used.
// R5 - Power-off bit removes comparator power; resets zero.
// R6 - Reference select chooses bandgap or positive pin.
// R7 - Chosen edge on result sets event flag.
// R8 - Mode: toggle, reserved, falling, rising.
// R9 - Flag clears on vector or written one.
// R10 - Request while flag, enable, global enable.
// R11 - Capture route feeds result to timer capture.
// R12 - Software disables interrupt before mode/power changes.
// R13 - Buffer disable forces pin-state bit zero.
// R14 - Software keeps converter power-reduction bit zero.
// R15 - Software waits for bandgap settling.
// R16 - Block only supplies the capture trigger.
// R17 - Converter enable off frees the multiplexer.
// R18 - Edges compare result with previous cycle.
module comparator_ctrl_irq (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmpRaw,
  input  wire logic [1:0]  pinLevel,
  input  wire logic        globalIrqEnable,
  input  wire logic        vectorTaken,
  output logic             cmpPowerOff,
  output logic             posUseBandgap,
  output logic             negUseMux,
  output logic      [2:0]  negMuxChannel,
  output logic             convEnable,
  output logic      [2:0]  trigSource,
  output logic             captureTrigger,
  output logic      [1:0]  pinBufferOff,
  output logic      [1:0]  pinState,
  output logic             cmpIrq,
  output logic             irq
);

  typedef struct packed {
    logic        powerOff;
    logic        refSelect;
    logic        eventFlag;
    logic        irqEnable;
    logic        captureRoute;
    logic [1:0]  irqMode;
    logic        negMuxEnable;
    logic [2:0]  trigSource;
    logic [1:0]  bufferOff;
    logic        convEnable;
    logic [2:0]  chanSelect;
    logic [1:0]  irqStatus;
    logic [1:0]  irqMask;
    logic        prevResult;
    logic [31:0] readData;
  } state_type;

  state_type                                s;
  state_type                                next_s;
  logic [comparator_ctrl_pkg::SYNC_WIDTH-1:0] syncBits;
  logic                                     result;
  logic [1:0]                               pinSynced;
  logic                                     rose;
  logic                                     fell;
  logic                                     cmpEvent;
  logic                                     setupPhase;
  logic                                     accessPhase;
  logic                                     writeEn;
  logic                                     mapped;
  logic                                     flagClear;
  logic                                     statusRead;

  bit_sync syncInst (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn ({pinLevel, cmpRaw}),
    .syncOut (syncBits)
  );

  assign result    = syncBits[0]; // R2
  assign pinSynced = syncBits[2:1];

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign writeEn     = accessPhase & pwrite & pstrb[0];

  always_comb begin
    unique case (paddr)
      comparator_ctrl_pkg::CMP_CTRL_ADDR,
      comparator_ctrl_pkg::CONV_CTRL_B_ADDR,
      comparator_ctrl_pkg::BUF_DISABLE_ADDR,
      comparator_ctrl_pkg::CONV_LINK_ADDR,
      comparator_ctrl_pkg::PIN_STATE_ADDR,
      comparator_ctrl_pkg::IRQ_STATUS_ADDR,
      comparator_ctrl_pkg::IRQ_MASK_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Edge detection against the previous cycle's result.
  assign rose = result & ~s.prevResult; // R18
  assign fell = ~result & s.prevResult; // R18

  always_comb begin
    unique case (s.irqMode)
      comparator_ctrl_pkg::MODE_TOGGLE:   cmpEvent = rose | fell; // R8
      comparator_ctrl_pkg::MODE_RESERVED: cmpEvent = 1'b0; // R8
      comparator_ctrl_pkg::MODE_FALLING:  cmpEvent = fell; // R8
      comparator_ctrl_pkg::MODE_RISING:   cmpEvent = rose; // R8
    endcase
  end

  assign flagClear  = vectorTaken | (writeEn && paddr == comparator_ctrl_pkg::CMP_CTRL_ADDR
                      && pwdata[comparator_ctrl_pkg::EVENT_FLAG_BIT]); // R9
  assign statusRead = accessPhase & ~pwrite & (paddr == comparator_ctrl_pkg::IRQ_STATUS_ADDR);

  always_comb begin
    next_s            = s;
    next_s.prevResult = result; // R18
    // A new event wins over a clear in the same cycle.
    next_s.eventFlag  = (s.eventFlag & ~flagClear) | cmpEvent; // R7 R9
    next_s.irqStatus  = (s.irqStatus & ~{2{statusRead}}) | {rose | fell, cmpEvent};
    if (writeEn) begin
      unique case (paddr)
        comparator_ctrl_pkg::CMP_CTRL_ADDR: begin
          next_s.powerOff     = pwdata[comparator_ctrl_pkg::POWER_OFF_BIT]; // R5
          next_s.refSelect    = pwdata[comparator_ctrl_pkg::REF_SELECT_BIT]; // R6
          next_s.irqEnable    = pwdata[comparator_ctrl_pkg::IRQ_ENABLE_BIT];
          next_s.captureRoute = pwdata[comparator_ctrl_pkg::CAPTURE_ROUTE_BIT];
          next_s.irqMode      = pwdata[comparator_ctrl_pkg::IRQ_MODE_LSB +: 2];
        end
        comparator_ctrl_pkg::CONV_CTRL_B_ADDR: begin
          next_s.negMuxEnable = pwdata[comparator_ctrl_pkg::NEG_MUX_ENABLE_BIT];
          next_s.trigSource   = pwdata[comparator_ctrl_pkg::TRIG_SOURCE_LSB +: 3];
        end
        comparator_ctrl_pkg::BUF_DISABLE_ADDR: begin
          next_s.bufferOff = pwdata[1:0];
        end
        comparator_ctrl_pkg::CONV_LINK_ADDR: begin
          next_s.convEnable = pwdata[comparator_ctrl_pkg::CONV_ENABLE_BIT]; // R17
          next_s.chanSelect = pwdata[comparator_ctrl_pkg::CHAN_SELECT_LSB +: 3];
        end
        comparator_ctrl_pkg::IRQ_MASK_ADDR: begin
          next_s.irqMask = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // Read data is captured in the setup cycle and held through the access.
    if (setupPhase) begin
      next_s.readData = 32'h0;
      unique case (paddr)
        comparator_ctrl_pkg::CMP_CTRL_ADDR: begin
          next_s.readData[7:0] = {s.powerOff, s.refSelect, result, s.eventFlag,
                                  s.irqEnable, s.captureRoute, s.irqMode}; // R1
        end
        comparator_ctrl_pkg::CONV_CTRL_B_ADDR: begin
          next_s.readData[7:0] = {1'b0, s.negMuxEnable, 3'h0, s.trigSource};
        end
        comparator_ctrl_pkg::BUF_DISABLE_ADDR: begin
          next_s.readData[1:0] = s.bufferOff;
        end
        comparator_ctrl_pkg::CONV_LINK_ADDR: begin
          next_s.readData[7:0] = {s.convEnable, 4'h0, s.chanSelect};
        end
        comparator_ctrl_pkg::PIN_STATE_ADDR: begin
          next_s.readData[1:0] = pinState;
        end
        comparator_ctrl_pkg::IRQ_STATUS_ADDR: begin
          // Events sampled at the setup edge are read too, so the clear cannot lose them.
          next_s.readData[1:0] = s.irqStatus | {rose | fell, cmpEvent};
        end
        comparator_ctrl_pkg::IRQ_MASK_ADDR: begin
          next_s.readData[1:0] = s.irqMask;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s            <= '0;
      s.irqMode    <= comparator_ctrl_pkg::IRQ_MODE_RESET;
      s.trigSource <= comparator_ctrl_pkg::TRIG_SOURCE_RESET;
      s.chanSelect <= comparator_ctrl_pkg::CHAN_SELECT_RESET;
      s.bufferOff  <= comparator_ctrl_pkg::BUF_OFF_RESET;
      s.irqMask    <= comparator_ctrl_pkg::IRQ_MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.readData;
  assign pready  = 1'b1;
  assign pslverr = accessPhase & ~mapped;

  assign cmpPowerOff    = s.powerOff; // R5
  assign posUseBandgap  = s.refSelect; // R6
  assign negUseMux      = s.negMuxEnable & ~s.convEnable; // R3 R4 R17
  assign negMuxChannel  = s.chanSelect; // R3
  assign convEnable     = s.convEnable;
  assign trigSource     = s.trigSource;
  // Only the trigger leaves here; the timer applies its own capture enable.
  assign captureTrigger = s.captureRoute & result; // R11 R16
  assign pinBufferOff   = s.bufferOff; // R13
  assign pinState       = pinSynced & ~s.bufferOff; // R13
  assign cmpIrq         = s.eventFlag & s.irqEnable & globalIrqEnable; // R10
  assign irq            = |(s.irqStatus & s.irqMask);

  resultSync_a : assert property (@(posedge mclk) disable iff (reset) // R2
    (!$past(reset, 1) && !$past(reset, 2)) |-> result == $past(cmpRaw, 2))
    else $error("result does not follow raw comparator after two edges");

  negMux_a : assert property (@(posedge mclk) disable iff (reset) // R3
    (s.negMuxEnable && !s.convEnable) |-> (negUseMux && negMuxChannel == s.chanSelect))
    else $error("negative mux not selected while enabled and converter off");

  negPin_a : assert property (@(posedge mclk) disable iff (reset) // R4
    (!s.negMuxEnable || s.convEnable) |-> !negUseMux)
    else $error("negative mux used while disabled or converter on");

  powerOff_a : assert property (@(posedge mclk) disable iff (reset) // R5
    (writeEn && paddr == comparator_ctrl_pkg::CMP_CTRL_ADDR) |=>
      cmpPowerOff == $past(pwdata[comparator_ctrl_pkg::POWER_OFF_BIT]))
    else $error("power-off output does not follow written bit");

  refSel_a : assert property (@(posedge mclk) disable iff (reset) // R6
    (writeEn && paddr == comparator_ctrl_pkg::CMP_CTRL_ADDR) |=>
      posUseBandgap == $past(pwdata[comparator_ctrl_pkg::REF_SELECT_BIT]))
    else $error("reference select output does not follow written bit");

  risingSet_a : assert property (@(posedge mclk) disable iff (reset) // R7
    (s.irqMode == comparator_ctrl_pkg::MODE_RISING && rose) |=> s.eventFlag)
    else $error("rising edge did not set event flag");

  fallingSet_a : assert property (@(posedge mclk) disable iff (reset) // R8
    (s.irqMode == comparator_ctrl_pkg::MODE_FALLING && rose && !s.eventFlag) |=> !s.eventFlag)
    else $error("rising edge set flag in falling mode");

  reservedMode_a : assert property (@(posedge mclk) disable iff (reset) // R8
    (s.irqMode == comparator_ctrl_pkg::MODE_RESERVED && !s.eventFlag) |=> !s.eventFlag)
    else $error("event flag set in reserved mode");

  flagClear_a : assert property (@(posedge mclk) disable iff (reset) // R9
    (vectorTaken && !cmpEvent) |=> !s.eventFlag)
    else $error("event flag not cleared by vector");

  flagKeep_a : assert property (@(posedge mclk) disable iff (reset) // R9
    (s.eventFlag && !vectorTaken && writeEn && paddr == comparator_ctrl_pkg::CMP_CTRL_ADDR
     && !pwdata[comparator_ctrl_pkg::EVENT_FLAG_BIT]) |=> s.eventFlag)
    else $error("writing zero cleared event flag");

  irqLine_a : assert property (@(posedge mclk) disable iff (reset) // R10
    ($rose(s.eventFlag) && s.irqEnable && globalIrqEnable) |-> cmpIrq)
    else $error("interrupt request missing after event");

  capture_a : assert property (@(posedge mclk) disable iff (reset) // R11
    (captureTrigger == (s.captureRoute && syncBits[0])) and (!s.captureRoute |-> !captureTrigger))
    else $error("capture trigger does not follow route and result");

  pinState_a : assert property (@(posedge mclk) disable iff (reset) // R13
    $rose(s.bufferOff[0]) |-> ##[0:2] (pinState[0] == 1'b0))
    else $error("pin state not forced low with buffer off");

  edgeOnce_a : assert property (@(posedge mclk) disable iff (reset) // R18
    (rose || fell) |-> result != $past(result))
    else $error("edge reported without result change");

  risingEvent_c : cover property (@(posedge mclk) disable iff (reset)
    s.irqMode == comparator_ctrl_pkg::MODE_RISING && rose ##1 s.eventFlag);

  toggleEvent_c : cover property (@(posedge mclk) disable iff (reset)
    s.irqMode == comparator_ctrl_pkg::MODE_TOGGLE && fell ##1 cmpIrq);

  captureActive_c : cover property (@(posedge mclk) disable iff (reset)
    $rose(captureTrigger));

  muxChannel_c : cover property (@(posedge mclk) disable iff (reset)
    negUseMux && negMuxChannel == 3'h7);

endmodule

// ==== rtl/comparator_ctrl_pkg.sv ====
package comparator_ctrl_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0]  CMP_CTRL_INDEX     = 8'h50;
  localparam logic [7:0]  CONV_CTRL_B_INDEX  = 8'h7b;
  localparam logic [7:0]  BUF_DISABLE_INDEX  = 8'h60;
  localparam logic [7:0]  CONV_LINK_INDEX    = 8'h61;
  localparam logic [7:0]  PIN_STATE_INDEX    = 8'h62;
  localparam logic [7:0]  IRQ_STATUS_INDEX   = 8'h63;
  localparam logic [7:0]  IRQ_MASK_INDEX     = 8'h64;

  localparam logic [11:0] CMP_CTRL_ADDR      = {2'h0, CMP_CTRL_INDEX, 2'h0};
  localparam logic [11:0] CONV_CTRL_B_ADDR   = {2'h0, CONV_CTRL_B_INDEX, 2'h0};
  localparam logic [11:0] BUF_DISABLE_ADDR   = {2'h0, BUF_DISABLE_INDEX, 2'h0};
  localparam logic [11:0] CONV_LINK_ADDR     = {2'h0, CONV_LINK_INDEX, 2'h0};
  localparam logic [11:0] PIN_STATE_ADDR     = {2'h0, PIN_STATE_INDEX, 2'h0};
  localparam logic [11:0] IRQ_STATUS_ADDR    = {2'h0, IRQ_STATUS_INDEX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR      = {2'h0, IRQ_MASK_INDEX, 2'h0};

  // Field positions in the comparator control and status register.
  localparam int POWER_OFF_BIT     = 7;
  localparam int REF_SELECT_BIT    = 6;
  localparam int RESULT_BIT        = 5;
  localparam int EVENT_FLAG_BIT    = 4;
  localparam int IRQ_ENABLE_BIT    = 3;
  localparam int CAPTURE_ROUTE_BIT = 2;
  localparam int IRQ_MODE_LSB      = 0;

  // Field positions in the converter control B register.
  localparam int NEG_MUX_ENABLE_BIT = 6;
  localparam int TRIG_SOURCE_LSB    = 0;

  // Field positions in the converter link register.
  localparam int CONV_ENABLE_BIT    = 7;
  localparam int CHAN_SELECT_LSB    = 0;

  // Interrupt status and mask bits.
  localparam int IRQ_EVENT_BIT      = 0;
  localparam int IRQ_CHANGE_BIT     = 1;

  // Interrupt mode codes.
  localparam logic [1:0] MODE_TOGGLE   = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALLING  = 2'h2;
  localparam logic [1:0] MODE_RISING   = 2'h3;

  // Values after reset.
  localparam logic [1:0] IRQ_MODE_RESET    = 2'h0;
  localparam logic [2:0] TRIG_SOURCE_RESET = 3'h0;
  localparam logic [2:0] CHAN_SELECT_RESET = 3'h0;
  localparam logic [1:0] BUF_OFF_RESET     = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET    = 2'h0;

  // Synchroniser: comparator output plus the two pin levels.
  localparam int SYNC_WIDTH = 3;

endpackage

// ==== test/comparator_ctrl_irq_tb.sv ====
module comparator_ctrl_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] ACTL = comparator_ctrl_pkg::CMP_CTRL_ADDR;
  localparam logic [11:0] ACB  = comparator_ctrl_pkg::CONV_CTRL_B_ADDR;
  localparam logic [11:0] ABUF = comparator_ctrl_pkg::BUF_DISABLE_ADDR;
  localparam logic [11:0] ALNK = comparator_ctrl_pkg::CONV_LINK_ADDR;
  localparam logic [11:0] APIN = comparator_ctrl_pkg::PIN_STATE_ADDR;
  localparam logic [11:0] ASTA = comparator_ctrl_pkg::IRQ_STATUS_ADDR;
  localparam logic [11:0] AMSK = comparator_ctrl_pkg::IRQ_MASK_ADDR;

  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmpRaw = 1'b0;
  logic [1:0]  pinLevel = 2'h0;
  logic        globalIrqEnable = 1'b0;
  logic        vectorTaken = 1'b0;
  logic        cmpPowerOff;
  logic        posUseBandgap;
  logic        negUseMux;
  logic [2:0]  negMuxChannel;
  logic        convEnable;
  logic [2:0]  trigSource;
  logic        captureTrigger;
  logic [1:0]  pinBufferOff;
  logic [1:0]  pinState;
  logic        cmpIrq;
  logic        irq;
  logic [31:0] rdat;
  logic        err;
  int          errorCnt = 0;
  int          numChecks = 0;

  always #4 mclk = ~mclk;

  comparator_ctrl_irq u_dut (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmpRaw(cmpRaw), .pinLevel(pinLevel),
    .globalIrqEnable(globalIrqEnable), .vectorTaken(vectorTaken),
    .cmpPowerOff(cmpPowerOff), .posUseBandgap(posUseBandgap), .negUseMux(negUseMux),
    .negMuxChannel(negMuxChannel), .convEnable(convEnable), .trigSource(trigSource),
    .captureTrigger(captureTrigger), .pinBufferOff(pinBufferOff), .pinState(pinState),
    .cmpIrq(cmpIrq), .irq(irq)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hf, rdat, err);
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00, 4'h0, rdat, err);
    check(rdat, exp);
  endtask

  task automatic setRaw(input logic v);
    @(posedge mclk);
    cmpRaw <= v;
    repeat (4) @(posedge mclk);
  endtask

  task automatic finishTest;
    $display("Checks: %0d, errors: %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    finishTest();
  end

  initial begin
    logic [11:0] regs [5];
    regs = '{ACTL, ACB, ABUF, ALNK, AMSK};
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    apb(1'b0, 12'h000, 8'h00, 4'h0, rdat, err);
    check({31'h0, err}, 32'h1);
    check(rdat, 32'h0);
    // Edge modes: rise then fall under each code, flag cleared by writing one.
    for (int m = 0; m < 4; m++) begin
      wr(ACTL, {6'h04, m[1:0]});
      setRaw(1'b1);
      rdchk(ACTL, {24'h0, 2'h0, 1'b1, (m == 0 || m == 3), 2'h0, m[1:0]});
      wr(ACTL, {6'h04, m[1:0]});
      setRaw(1'b0);
      rdchk(ACTL, {24'h0, 3'h0, (m == 0 || m == 2), 2'h0, m[1:0]});
    end
    // Interrupt request path, vector clear, status and mask.
    rdchk(ASTA, 32'h3);
    wr(AMSK, 8'h03);
    globalIrqEnable <= 1'b1;
    wr(ACTL, 8'h0b);
    setRaw(1'b1);
    check({31'h0, cmpIrq}, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(ACTL, 8'h0b);
    check({31'h0, cmpIrq}, 32'h1);
    globalIrqEnable <= 1'b0;
    @(posedge mclk);
    check({31'h0, cmpIrq}, 32'h0);
    globalIrqEnable <= 1'b1;
    vectorTaken <= 1'b1;
    @(posedge mclk);
    vectorTaken <= 1'b0;
    @(posedge mclk);
    check({31'h0, cmpIrq}, 32'h0);
    rdchk(ASTA, 32'h3);
    rdchk(ASTA, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(AMSK, 8'h01);
    setRaw(1'b0);
    check({31'h0, irq}, 32'h0);
    rdchk(ASTA, 32'h2);
    rdchk(ACTL, 32'h0b);
    wr(ACTL, 8'h03);
    wr(ACTL, 8'h00);
    // Capture route, power and reference selection.
    setRaw(1'b1);
    wr(ACTL, 8'h14);
    check({31'h0, captureTrigger}, 32'h1);
    rdchk(ACTL, 32'h24);
    wr(ACTL, 8'hc0);
    check({31'h0, captureTrigger}, 32'h0);
    check({30'h0, cmpPowerOff, posUseBandgap}, 32'h3);
    wr(ACTL, 8'h10);
    check({30'h0, cmpPowerOff, posUseBandgap}, 32'h0);
    // Negative input selection and converter control B.
    wr(ACB, 8'h45);
    rdchk(ACB, 32'h45);
    check({29'h0, trigSource}, 32'h5);
    wr(ACB, 8'hff);
    rdchk(ACB, 32'h47);
    for (int c = 0; c < 8; c++) begin
      wr(ALNK, c[7:0]);
      check({28'h0, negUseMux, negMuxChannel}, {28'h1, c[2:0]});
    end
    wr(ALNK, 8'h83);
    check({30'h0, negUseMux, convEnable}, 32'h1);
    apb(1'b1, ALNK, 8'h05, 4'h0, rdat, err);
    rdchk(ALNK, 32'h83);
    wr(ALNK, 8'h03);
    wr(ACB, 8'h00);
    check({31'h0, negUseMux}, 32'h0);
    // Pin buffers and pin state.
    pinLevel <= 2'h3;
    repeat (4) @(posedge mclk);
    check({30'h0, pinState}, 32'h3);
    rdchk(APIN, 32'h3);
    wr(ABUF, 8'h01);
    check({28'h0, pinBufferOff, pinState}, 32'h6);
    rdchk(APIN, 32'h2);
    rdchk(ABUF, 32'h1);
    finishTest();
  end
endmodule
